// ==== verilog/pcstp_top.sv ====
`timescale 1ns/100ps
// Behaviour
// R1: allowed and awake: size code 0b11, four address payload bytes.
// R2: allowed and sleeping: size code 0b01, one payload byte all zero.
// R3: prohibited: size code 0b01, one payload byte all ones.
// R4: sync packet is at least 47 zero bits then one set bit.
// R5: minimal sync: byte 5 bit 7 set marks packet end.
// R6: minimal sync: bytes 0 to 4 and byte 5 bits 6:0 are zero.
// R7: capture hardware finds sync pattern to learn byte alignment.
// R8: only the six-byte sync form is generated.
// R9: header is 0b00010, source bit one, size code in bits 1:0.
// R10: samples at fixed counter interval, only while sampling enabled.
// R11: address payload bytes go least significant byte first.
module pcstp_top #(
	parameter logic [15:0] INTERVAL = pcstp_pkg::INTERVAL_DEF
) (
	input  wire logic       i_mclk,           // 100 MHz clock
	input  wire logic       i_reset_n,        // async reset, active low
	input  wire logic       i_sample_enable,  // sampling on
	input  wire logic       i_allowed,        // sampling allowed
	input  wire logic       i_sleeping,       // processor sleeping
	input  wire logic [31:0] i_addr,          // sampled instruction address
	input  wire logic       i_sync_req,       // request sync packet
	input  wire logic       i_ready,          // sink accepts byte
	output logic            o_valid,          // byte valid
	output logic      [7:0] o_data,           // byte
	output logic            o_last,           // last byte of packet
	output logic            o_drop            // sample lost while busy, pulse
);
	typedef enum logic [1:0] {IDLE, FETCH, SEND} pcstp_state_t;

	pcstp_state_t state_reg;
	logic [15:0]  cnt_reg;
	logic [2:0]   idx_reg;
	logic [2:0]   len_reg;
	logic         sync_pend_reg;
	logic         samp_pend_reg;
	pcstp_pkg::pcstp_sample_t samp_reg;
	logic [7:0]   rom_data;

	wire tick      = i_sample_enable && (cnt_reg == INTERVAL - 16'h0001);
	wire start_any = (state_reg == IDLE) && (sync_pend_reg || samp_pend_reg);
	wire start_syn = start_any && sync_pend_reg;
	wire full_samp = samp_reg.allowed && !samp_reg.sleeping;
	wire [1:0] size_code = full_samp ? pcstp_pkg::SS_FOUR_BYTE    // R1
	                                 : pcstp_pkg::SS_ONE_BYTE;   // R2 R3
	wire [7:0] header = {pcstp_pkg::HDR_DISC, pcstp_pkg::HDR_SRC_HW, size_code}; // R9
	wire [7:0] short_pay = samp_reg.allowed ? pcstp_pkg::PAY_SLEEP     // R2
	                                        : pcstp_pkg::PAY_PROHIBIT; // R3
	wire [47:0] samp_img = full_samp ? {8'h00, samp_reg.addr, header}  // R11
	                                 : {32'h0000_0000, short_pay, header};
	wire [47:0] sync_img = {pcstp_pkg::SYNC_LAST, {4{pcstp_pkg::SYNC_ZERO}},
	                        pcstp_pkg::SYNC_ZERO};                    // R4 R5 R6 R8
	wire [2:0] samp_len = full_samp ? 3'(pcstp_pkg::LONG_BYTES)
	                                : 3'(pcstp_pkg::SHORT_BYTES);
	wire accept   = o_valid && i_ready;
	wire pkt_done = accept && o_last;

	pcstp_pkt_rom u_rom (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_load    (start_any),
		.i_image   (start_syn ? sync_img : samp_img),
		.i_idx     (idx_reg),
		.o_rdata   (rom_data)
	);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			cnt_reg <= 16'h0000;
		else if (!i_sample_enable || tick)
			cnt_reg <= 16'h0000;                                  // R10
		else
			cnt_reg <= cnt_reg + 16'h0001;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			samp_pend_reg <= 1'b0;
			sync_pend_reg <= 1'b0;
			samp_reg      <= '0;
			o_drop        <= 1'b0;
		end else begin
			o_drop <= tick && samp_pend_reg && !(start_any && !start_syn);
			if (tick) begin
				samp_pend_reg <= 1'b1;                            // R10
				samp_reg      <= '{i_allowed, i_sleeping, i_addr};
			end else if (start_any && !start_syn)
				samp_pend_reg <= 1'b0;
			if (i_sync_req)
				sync_pend_reg <= 1'b1;
			else if (start_syn)
				sync_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= IDLE;
			idx_reg   <= 3'h0;
			len_reg   <= 3'h0;
			o_valid   <= 1'b0;
			o_data    <= 8'h00;
			o_last    <= 1'b0;
		end else begin
			case (state_reg)
				IDLE: begin
					if (start_any) begin
						state_reg <= FETCH;
						idx_reg   <= 3'h0;
						len_reg   <= start_syn ? 3'(pcstp_pkg::SYNC_BYTES) : samp_len;
					end
				end
				FETCH: begin
					if (!o_valid || accept) begin
						state_reg <= SEND;
						o_valid   <= 1'b0;
					end
				end
				SEND: begin
					o_valid   <= 1'b1;
					o_data    <= rom_data;
					o_last    <= (idx_reg == len_reg - 3'h1);
					idx_reg   <= idx_reg + 3'h1;
					state_reg <= (idx_reg == len_reg - 3'h1) ? IDLE : FETCH;
				end
				default: state_reg <= IDLE;
			endcase
			if (state_reg != SEND && pkt_done) begin
				o_valid <= 1'b0;
				o_last  <= 1'b0;
			end else if (state_reg == IDLE && accept)
				o_valid <= 1'b0;
		end
	end
endmodule : pcstp_top

// ==== pkg/pcstp_pkg.sv ====
package pcstp_pkg;
	localparam logic [4:0] HDR_DISC      = 5'h02;
	localparam logic       HDR_SRC_HW    = 1'b1;
	localparam logic [1:0] SS_ONE_BYTE   = 2'h1;
	localparam logic [1:0] SS_FOUR_BYTE  = 2'h3;
	localparam logic [7:0] PAY_SLEEP     = 8'h00;
	localparam logic [7:0] PAY_PROHIBIT  = 8'hFF;
	localparam logic [7:0] SYNC_ZERO     = 8'h00;
	localparam logic [7:0] SYNC_LAST     = 8'h80;
	localparam int         SYNC_BYTES    = 6;
	localparam int         LONG_BYTES    = 5;
	localparam int         SHORT_BYTES   = 2;
	localparam logic [15:0] INTERVAL_DEF = 16'h0040;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} pcstp_byte_t;

	typedef struct packed {
		logic        allowed;
		logic        sleeping;
		logic [31:0] addr;
	} pcstp_sample_t;
endpackage : pcstp_pkg

// ==== verilog/pcstp_pkt_rom.sv ====
`timescale 1ns/100ps
// holds one packet image; read data registered
module pcstp_pkt_rom (
	input  wire logic       i_mclk,    // clock
	input  wire logic       i_reset_n, // async reset, active low
	input  wire logic       i_load,    // capture new image
	input  wire logic [47:0] i_image,  // packet bytes, byte 0 low
	input  wire logic [2:0] i_idx,     // byte index
	output logic      [7:0] o_rdata    // registered byte
);
	logic [47:0] image_reg;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			image_reg <= 48'h0000_0000_0000;
			o_rdata   <= 8'h00;
		end else begin
			if (i_load)
				image_reg <= i_image;
			o_rdata <= image_reg[i_idx*8 +: 8];
		end
	end
endmodule : pcstp_pkt_rom

// ==== verif/pcstp_asserts.sv ====
`timescale 1ns/100ps
module pcstp_asserts (
	input  wire logic       i_mclk,    // clock
	input  wire logic       i_reset_n, // reset
	input  wire logic       i_ready,   // sink ready
	input  wire logic       o_valid,   // byte valid
	input  wire logic [7:0] o_data,    // byte
	input  wire logic       o_last,    // last byte
	input  wire logic       o_drop     // drop pulse
);
	logic [2:0] idx_reg;
	logic [7:0] hdr_reg;
	wire        acc = o_valid && i_ready;
	// byte position and header of the packet in flight
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			idx_reg <= 3'h0;
			hdr_reg <= 8'h00;
		end else if (acc) begin
			idx_reg <= o_last ? 3'h0 : idx_reg + 3'h1;
			if (idx_reg == 3'h0)
				hdr_reg <= o_data;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_end; acc && o_last; endsequence
	property p_hold; o_valid && !i_ready |=> o_valid && $stable(o_data); endproperty
	property p_gap; s_end |=> !o_valid; endproperty
	property p_drop; o_drop |=> !o_drop; endproperty
	property p_first; o_valid && idx_reg == 3'h0 |->
		o_data == 8'h00 || (o_data[7:2] == 6'h05 && o_data[1:0] != 2'h2); endproperty
	property p_short; o_valid && idx_reg != 3'h0 && hdr_reg == 8'h15 |->
		o_last && (o_data == 8'h00 || o_data == 8'hff); endproperty
	property p_long; o_valid && idx_reg != 3'h0 && hdr_reg == 8'h17 |->
		o_last == (idx_reg == 3'h4); endproperty
	property p_sync; o_valid && idx_reg != 3'h0 && hdr_reg == 8'h00 |->
		o_data == {idx_reg == 3'h5, 7'h00} && o_last == (idx_reg == 3'h5); endproperty
	property p_len; o_valid && hdr_reg == 8'h00 |-> idx_reg <= 3'h5; endproperty
	a_hold: assert property (p_hold) else $error("byte changed before accept");
	a_gap: assert property (p_gap) else $error("no gap after packet");
	a_drop: assert property (p_drop) else $error("drop not a pulse");
	a_first: assert property (p_first) else $error("bad first byte");
	a_short: assert property (p_short) else $error("bad short payload");
	a_long: assert property (p_long) else $error("bad long length");
	a_sync: assert property (p_sync) else $error("bad sync byte");
	a_len: assert property (p_len) else $error("sync too long");
endmodule : pcstp_asserts
bind pcstp_top pcstp_asserts u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ready(i_ready),
	.o_valid(o_valid), .o_data(o_data), .o_last(o_last), .o_drop(o_drop));

// ==== verif/pcstp_sink.sv ====
`timescale 1ns/100ps
module pcstp_sink (
	input  wire logic i_mclk,    // clock
	input  wire logic i_reset_n, // reset
	input  wire logic i_slow,    // stall every other cycle
	output logic      o_ready    // accepts byte
);
	logic tog_reg;
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			tog_reg <= 1'b0;
		else
			tog_reg <= !tog_reg;
	end
	assign o_ready = !i_slow || tog_reg;
endmodule : pcstp_sink

// ==== verif/pcstp_top_tb_top.sv ====
`timescale 1ns/100ps
module pcstp_top_tb_top;
	logic        i_mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        en = 1'b0, al = 1'b1, sl = 1'b0, sync = 1'b0, slow = 1'b0;
	logic [31:0] addr = 32'h1234_5678;
	logic        rdy, vld, last, drop;
	logic [7:0]  dat;
	int          errors = 0, cmp_count = 0;
	always #5 i_mclk = !i_mclk;
	pcstp_top #(.INTERVAL(16'h0008)) u_dut (.i_mclk(i_mclk), .i_reset_n(rst_n),
		.i_sample_enable(en), .i_allowed(al), .i_sleeping(sl), .i_addr(addr),
		.i_sync_req(sync), .i_ready(rdy), .o_valid(vld), .o_data(dat), .o_last(last),
		.o_drop(drop));
	pcstp_sink u_sink (.i_mclk(i_mclk), .i_reset_n(rst_n), .i_slow(slow), .o_ready(rdy));
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// waits for the next accepted byte, checks {last, data}
	task automatic get(input logic [8:0] exp);
		int n;
		n = 0;
		@(posedge i_mclk);
		while (!(vld && rdy) && n < 60) begin
			@(posedge i_mclk);
			n++;
		end
		chk({last, dat}, exp);
	endtask : get
	task automatic t_sample(input logic a, input logic s);
		@(posedge i_mclk);
		al <= a;
		sl <= s;
		en <= 1'b1;
		get({1'b0, (a && !s) ? 8'h17 : 8'h15});
		en <= 1'b0;
		if (a && !s)
			for (int i = 0; i < 4; i++) get({i == 3, addr[8*i +: 8]});
		else
			get({1'b1, a ? 8'h00 : 8'hff});
	endtask : t_sample
	task automatic t_sync;
		@(posedge i_mclk);
		sync <= 1'b1;
		@(posedge i_mclk);
		sync <= 1'b0;
		for (int i = 0; i < 6; i++) get({i == 5, i == 5 ? 8'h80 : 8'h00});
	endtask : t_sync
	task automatic t_drop;
		logic seen;
		seen = 1'b0;
		al <= 1'b1;
		sl <= 1'b0;
		en <= 1'b1;
		repeat (60) begin
			@(posedge i_mclk);
			seen |= drop;
		end
		en <= 1'b0;
		chk({8'h00, seen}, 9'h001);
		repeat (40) @(posedge i_mclk);
	endtask : t_drop
	task automatic close_out;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	initial begin
		repeat (20) @(posedge i_mclk);
		rst_n <= 1'b1;
		t_sample(1'b1, 1'b0);
		t_sample(1'b1, 1'b1);
		t_sample(1'b0, 1'b0);
		slow <= 1'b1;
		t_sync;
		t_drop;
		close_out;
	end
	initial begin
		#20000;
		errors++;
		close_out;
	end
endmodule : pcstp_top_tb_top
